//--- pg_pkg.sv
// Constants shared by the power-good supervisor and its helpers.
// Assumes one 200 MHz clock and a 32-bit Avalon-MM register bus.
package pg_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned RAIL_N = 6;
  localparam int unsigned VCODE_W = 7;
  localparam int unsigned EDGE_N = 5;

  // ==========================================================================
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FAULT_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_RAIL_EN = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DISCH = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_VCODE1 = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_VCODE2 = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;

  // ==========================================================================
  // Field positions
  localparam int unsigned CTRL_SOFT_SHUTDOWN_BIT_BIT = 0;
  localparam int unsigned CTRL_ALWAYS_ON_BIT = 1;
  localparam int unsigned ST_RESUME_BIT = 0;
  localparam int unsigned ST_PLATFORM_BIT = 1;
  localparam int unsigned ST_THERM_ARMED_BIT = 2;
  localparam int unsigned ST_JOINED_BIT = 3;
  localparam int unsigned ST_FAULT_BIT = 4;
  localparam int unsigned ST_RAIL_FAULT_LSB = 8;
  localparam int unsigned ST_RAIL_GOOD_LSB = 16;

  // ==========================================================================
  // Values after reset or register clear
  localparam logic CTRL_ALWAYS_ON_RST = 1'b0;
  localparam logic [RAIL_N-1:0] FAULT_MASK_RST = 6'h00;
  localparam logic [RAIL_N-1:0] RAIL_EN_RST = 6'h00;
  localparam logic [RAIL_N-1:0] DISCH_RST = 6'h3F;
  localparam logic [VCODE_W-1:0] VCODE_RST = 7'h00;

  // ==========================================================================
  // Edge detector slots and their idle levels
  localparam int unsigned EDGE_CHIP_EN = 0;
  localparam int unsigned EDGE_THERM = 1;
  localparam int unsigned EDGE_IDLE = 2;
  localparam int unsigned EDGE_S3 = 3;
  localparam int unsigned EDGE_CRIT = 4;
  localparam logic [EDGE_N-1:0] EDGE_INIT = 5'h0E;

endpackage

//--- pg_edge_detect.sv
// Registered edge detector for a group of level inputs.
// Assumes the inputs are already synchronous to i_clk.
`timescale 1ns/1ps
module pg_edge_detect #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Levels in, one-cycle pulses out
  input wire logic [W-1:0] i_level,
  output logic [W-1:0] o_rise,
  output logic [W-1:0] o_fall
);

  typedef struct packed {
    logic [W-1:0] prev_q;
  } edge_state_t;

  edge_state_t s_q;
  edge_state_t s_d;

  // ==========================================================================
  // Next state: remember last level
  always_comb begin
    s_d = s_q;
    s_d.prev_q = i_level;
  end

  // Reset to the idle levels so no false edge follows reset
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s_q.prev_q <= INIT;
    end else begin
      s_q <= s_d;
    end
  end

  // Pulses
  assign o_rise = i_level & ~s_q.prev_q;
  assign o_fall = ~i_level & s_q.prev_q;

endmodule // pg_edge_detect

//--- pg_avmm_slave.sv
// Avalon-MM slave front end: one wait state on every access.
// Assumes the master holds its request until waitrequest is low.
`timescale 1ns/1ps
module pg_avmm_slave (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Avalon-MM slave
  input wire logic i_read,
  input wire logic i_write,
  output logic o_waitrequest,
  output logic [pg_pkg::DATA_W-1:0] o_readdata,
  // Core side
  input wire logic [pg_pkg::DATA_W-1:0] i_rd_value,
  output logic o_wr_stb
);

  typedef struct packed {
    logic ack_q;
    logic [pg_pkg::DATA_W-1:0] rdata_q;
  } bus_state_t;

  bus_state_t s_q;
  bus_state_t s_d;
  logic req;

  // ==========================================================================
  // First cycle of a request captures read data, second cycle releases it
  always_comb begin
    s_d = s_q;
    req = i_read | i_write;
    s_d.ack_q = req & ~s_q.ack_q;
    if (i_read && !s_q.ack_q) begin
      s_d.rdata_q = i_rd_value;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Handshake is combinational so the wait drops exactly one cycle late
  assign o_waitrequest = (i_read | i_write) & ~s_q.ack_q;
  assign o_readdata = s_q.rdata_q;
  assign o_wr_stb = i_write & s_q.ack_q;

endmodule // pg_avmm_slave

//--- pg_supervisor.sv
// Power-good trees, register clear and rail control registers.
// Assumes all supervision inputs are synchronous to i_clk and that
// analog comparators deliver the undervoltage and supply-low levels.
// Outputs lag a lost qualifier by one cycle.
// Level clear causes repeat the clear.
//
// Overview of operation
// - Enabled rail disconnects its discharge resistor itself
// - Resume good needs supply, enable, thermal, rails 1/4/5
// - Platform ok adds both sleeps, rails 6/3/2
// - Any lost qualifier or unmasked fault drops outputs
// - Thermal trip ignored until resume good first asserted
// - Rail1 joins platform tree after first platform ok
// - Supply below reset threshold clears all registers
// - Enable falling clears registers unless LDO always-on
// - Thermal falling while resume good clears registers
// - Unmasked rail fault clears registers
// - Critical temperature shutdown clears registers
// - Writing soft shutdown bit clears registers
// - Idle or S3 sleep falling clears voltage codes
`timescale 1ns/1ps
module pg_supervisor (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Avalon-MM slave
  input wire logic [pg_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [pg_pkg::DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic o_avs_waitrequest,
  output logic [pg_pkg::DATA_W-1:0] o_avs_readdata,
  // Supply and chip-level inputs
  input wire logic i_input_undervoltage_ok,
  input wire logic i_system_supply_low,
  input wire logic i_chip_enable_in,
  input wire logic i_thermal_trip_n,
  input wire logic i_crit_temp,
  // Sleep-state inputs, active low
  input wire logic i_sleep_s4_n,
  input wire logic i_sleep_s3_n,
  input wire logic i_idle_sleep_n,
  // Per-rail status
  input wire logic i_rail1_good,
  input wire logic i_rail2_good,
  input wire logic i_rail3_good,
  input wire logic i_rail4_good,
  input wire logic i_rail5_good,
  input wire logic i_rail6_good,
  input wire logic [pg_pkg::RAIL_N-1:0] i_rail_fault,
  // Power-good outputs
  output logic o_resume_reset_good_n,
  output logic o_platform_power_ok,
  // Rail control outputs
  output logic [pg_pkg::RAIL_N-1:0] o_rail_enable,
  output logic [pg_pkg::RAIL_N-1:0] o_discharge_on,
  output logic [pg_pkg::VCODE_W-1:0] o_rail1_vcode,
  output logic [pg_pkg::VCODE_W-1:0] o_rail2_vcode,
  output logic o_register_clear
);

  // ==========================================================================
  // State
  typedef struct packed {
    // Software registers, plus the registered discharge outputs
    logic always_on;
    logic [pg_pkg::RAIL_N-1:0] fault_mask;
    logic [pg_pkg::RAIL_N-1:0] rail_en;
    logic [pg_pkg::RAIL_N-1:0] disch;
    logic [pg_pkg::RAIL_N-1:0] disch_on;
    logic [pg_pkg::VCODE_W-1:0] vcode1;
    logic [pg_pkg::VCODE_W-1:0] vcode2;
    // Flags
    logic therm_armed;
    logic rail1_joined;
    // Outputs
    logic resume_good;
    logic platform_ok;
    logic clear;
  } sup_state_t;

  sup_state_t s_q;
  sup_state_t s_d;

  // Edge detector
  logic [pg_pkg::EDGE_N-1:0] edge_level;
  logic [pg_pkg::EDGE_N-1:0] edge_rise;
  logic [pg_pkg::EDGE_N-1:0] edge_fall;

  // Discharge
  logic [pg_pkg::RAIL_N-1:0] disch_on_c;

  // Register bus
  logic [pg_pkg::DATA_W-1:0] rd_value;
  logic wr_stb;
  logic wr_lane0;

  // Tree terms
  logic fault_any;
  logic therm_hit;
  logic base_ok;
  logic resume_c;
  logic platform_c;

  // Clear terms
  logic soft_soft_shutdown_bit;
  logic clear_c;

  // ==========================================================================
  // Address decode, used by both the write and the read path
  function automatic logic reg_hit(input logic [pg_pkg::ADDR_W-1:0] addr,
                                   input logic [pg_pkg::ADDR_W-1:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  // ==========================================================================
  // Bus front end
  // One wait state per access
  pg_avmm_slave u_bus (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_read(i_avs_read),
    .i_write(i_avs_write),
    .o_waitrequest(o_avs_waitrequest),
    .o_readdata(o_avs_readdata),
    .i_rd_value(rd_value),
    .o_wr_stb(wr_stb)
  );

  // Every writable field fits in byte lane 0, so only that lane gates writes
  assign wr_lane0 = wr_stb & i_avs_byteenable[0];

  // ==========================================================================
  // Edge detection on chip-level and sleep inputs
  assign edge_level[pg_pkg::EDGE_CHIP_EN] = i_chip_enable_in;
  assign edge_level[pg_pkg::EDGE_THERM] = i_thermal_trip_n;
  assign edge_level[pg_pkg::EDGE_IDLE] = i_idle_sleep_n;
  assign edge_level[pg_pkg::EDGE_S3] = i_sleep_s3_n;
  assign edge_level[pg_pkg::EDGE_CRIT] = i_crit_temp;

  // Idle levels, no false edge after reset
  pg_edge_detect #(
    .W(pg_pkg::EDGE_N),
    .INIT(pg_pkg::EDGE_INIT)
  ) u_edges (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_level(edge_level),
    .o_rise(edge_rise),
    .o_fall(edge_fall)
  );

  // ==========================================================================
  // Discharge control: an enabled rail keeps its resistor on one cycle at most
  // Registered, no glitch on a write
  genvar gi;
  generate
    for (gi = 0; gi < pg_pkg::RAIL_N; gi++) begin : g_disch
      assign disch_on_c[gi] = s_q.disch[gi] & ~s_q.rail_en[gi];
    end
  endgenerate

  // ==========================================================================
  // Power-good trees; a registered stage keeps the outputs glitch free,
  // at the cost of one cycle of latency on deassertion
  always_comb begin
    // Masked faults ignored
    fault_any = (|(i_rail_fault & ~s_q.fault_mask)) | i_crit_temp;
    // Trip counts once armed
    therm_hit = s_q.therm_armed & ~i_thermal_trip_n;

    // Shared by both trees
    base_ok = i_input_undervoltage_ok & i_chip_enable_in & ~therm_hit & ~fault_any;
    resume_c = base_ok & i_rail1_good & i_rail4_good & i_rail5_good;

    // Rail1 once joined
    platform_c = base_ok & i_rail4_good & i_rail5_good
               & i_sleep_s4_n & i_sleep_s3_n
               & i_rail6_good & i_rail3_good & i_rail2_good
               & (~s_q.rail1_joined | i_rail1_good);
  end

  // ==========================================================================
  // Register clear causes, merged into one registered pulse
  always_comb begin
    soft_soft_shutdown_bit = wr_lane0 & reg_hit(i_avs_address, pg_pkg::OFS_CTRL)
              & i_avs_writedata[pg_pkg::CTRL_SOFT_SHUTDOWN_BIT_BIT];

    // Level causes repeat
    clear_c = i_system_supply_low
            | (edge_fall[pg_pkg::EDGE_CHIP_EN] & ~s_q.always_on)
            | (edge_fall[pg_pkg::EDGE_THERM] & s_q.resume_good)
            | (|(i_rail_fault & ~s_q.fault_mask))
            | edge_rise[pg_pkg::EDGE_CRIT]
            | soft_soft_shutdown_bit;
  end

  // ==========================================================================
  // Next state
  always_comb begin
    s_d = s_q;

    // Registered trees
    s_d.clear = clear_c;
    s_d.disch_on = disch_on_c;
    s_d.resume_good = resume_c;
    s_d.platform_ok = platform_c;

    // Thermal trip starts counting once resume good has been seen
    // Only a clear disarms it
    if (s_q.resume_good) begin
      s_d.therm_armed = 1'b1;
    end

    // Rail1 leaves the platform tree on every enable rise until rejoined
    // Enable rise never meets platform ok
    if (edge_rise[pg_pkg::EDGE_CHIP_EN]) begin
      s_d.rail1_joined = 1'b0;
    end else if (s_q.platform_ok) begin
      s_d.rail1_joined = 1'b1;
    end

    // Software writes
    if (wr_lane0) begin
      if (reg_hit(i_avs_address, pg_pkg::OFS_CTRL)) begin
        s_d.always_on = i_avs_writedata[pg_pkg::CTRL_ALWAYS_ON_BIT];
      end

      if (reg_hit(i_avs_address, pg_pkg::OFS_FAULT_MASK)) begin
        s_d.fault_mask = i_avs_writedata[pg_pkg::RAIL_N-1:0];
      end

      if (reg_hit(i_avs_address, pg_pkg::OFS_RAIL_EN)) begin
        s_d.rail_en = i_avs_writedata[pg_pkg::RAIL_N-1:0];
      end

      if (reg_hit(i_avs_address, pg_pkg::OFS_DISCH)) begin
        s_d.disch = i_avs_writedata[pg_pkg::RAIL_N-1:0];
      end

      if (reg_hit(i_avs_address, pg_pkg::OFS_VCODE1)) begin
        s_d.vcode1 = i_avs_writedata[pg_pkg::VCODE_W-1:0];
      end

      if (reg_hit(i_avs_address, pg_pkg::OFS_VCODE2)) begin
        s_d.vcode2 = i_avs_writedata[pg_pkg::VCODE_W-1:0];
      end
    end

    // Sleep entry drops the scaled-rail codes; beats a write in the same cycle
    if (edge_fall[pg_pkg::EDGE_IDLE] || edge_fall[pg_pkg::EDGE_S3]) begin
      s_d.vcode1 = pg_pkg::VCODE_RST;
      s_d.vcode2 = pg_pkg::VCODE_RST;
    end

    // Global clear wins over everything; every software register and flag sees it together
    if (s_q.clear) begin
      s_d.always_on = pg_pkg::CTRL_ALWAYS_ON_RST;
      s_d.fault_mask = pg_pkg::FAULT_MASK_RST;
      s_d.rail_en = pg_pkg::RAIL_EN_RST;
      s_d.disch = pg_pkg::DISCH_RST;
      s_d.vcode1 = pg_pkg::VCODE_RST;
      s_d.vcode2 = pg_pkg::VCODE_RST;

      // Flags restart
      s_d.therm_armed = 1'b0;
      s_d.rail1_joined = 1'b0;
    end
  end

  // ==========================================================================
  // State register
  // Same values as the clear
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s_q.always_on <= pg_pkg::CTRL_ALWAYS_ON_RST;
      s_q.fault_mask <= pg_pkg::FAULT_MASK_RST;
      s_q.rail_en <= pg_pkg::RAIL_EN_RST;
      s_q.disch <= pg_pkg::DISCH_RST;
      s_q.disch_on <= pg_pkg::DISCH_RST;
      s_q.vcode1 <= pg_pkg::VCODE_RST;
      s_q.vcode2 <= pg_pkg::VCODE_RST;

      // Flags and outputs
      s_q.therm_armed <= 1'b0;
      s_q.rail1_joined <= 1'b0;
      s_q.resume_good <= 1'b0;
      s_q.platform_ok <= 1'b0;
      s_q.clear <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Read mux; soft shutdown reads back as zero since it acts once
  always_comb begin
    rd_value = '0;
    // Unmapped reads give zero
    if (reg_hit(i_avs_address, pg_pkg::OFS_CTRL)) begin
      rd_value[pg_pkg::CTRL_ALWAYS_ON_BIT] = s_q.always_on;
    end else if (reg_hit(i_avs_address, pg_pkg::OFS_FAULT_MASK)) begin
      rd_value[pg_pkg::RAIL_N-1:0] = s_q.fault_mask;
    end else if (reg_hit(i_avs_address, pg_pkg::OFS_RAIL_EN)) begin
      rd_value[pg_pkg::RAIL_N-1:0] = s_q.rail_en;
    end else if (reg_hit(i_avs_address, pg_pkg::OFS_DISCH)) begin
      rd_value[pg_pkg::RAIL_N-1:0] = s_q.disch;
    end else if (reg_hit(i_avs_address, pg_pkg::OFS_VCODE1)) begin
      rd_value[pg_pkg::VCODE_W-1:0] = s_q.vcode1;
    end else if (reg_hit(i_avs_address, pg_pkg::OFS_VCODE2)) begin
      rd_value[pg_pkg::VCODE_W-1:0] = s_q.vcode2;
    end else if (reg_hit(i_avs_address, pg_pkg::OFS_STATUS)) begin
      // Registered flags, then live fault and rail inputs
      rd_value[pg_pkg::ST_RESUME_BIT] = s_q.resume_good;
      rd_value[pg_pkg::ST_PLATFORM_BIT] = s_q.platform_ok;
      rd_value[pg_pkg::ST_THERM_ARMED_BIT] = s_q.therm_armed;
      rd_value[pg_pkg::ST_JOINED_BIT] = s_q.rail1_joined;
      rd_value[pg_pkg::ST_FAULT_BIT] = fault_any;
      rd_value[pg_pkg::ST_RAIL_FAULT_LSB +: pg_pkg::RAIL_N] = i_rail_fault;
      rd_value[pg_pkg::ST_RAIL_GOOD_LSB +: pg_pkg::RAIL_N] =
        {i_rail6_good, i_rail5_good, i_rail4_good,
         i_rail3_good, i_rail2_good, i_rail1_good};
    end
  end

  // ==========================================================================
  // Outputs, all from flip-flops
  assign o_resume_reset_good_n = s_q.resume_good;
  assign o_platform_power_ok = s_q.platform_ok;

  // Rail control
  assign o_rail_enable = s_q.rail_en;
  assign o_discharge_on = s_q.disch_on;
  assign o_rail1_vcode = s_q.vcode1;
  assign o_rail2_vcode = s_q.vcode2;

  // Clear pulse
  assign o_register_clear = s_q.clear;

endmodule // pg_supervisor

//--- pg_supervisor_sva.sv
// Checker for the power-good supervisor: relations between its ports over time.
// Assumes one clock and a synchronous active-high reset; bound to pg_supervisor.
`timescale 1ns/1ps
module pg_supervisor_sva (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Register bus
  input wire logic [pg_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_write,
  input wire logic [pg_pkg::DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic o_avs_waitrequest,
  // Supervision inputs
  input wire logic i_input_undervoltage_ok,
  input wire logic i_system_supply_low,
  input wire logic i_chip_enable_in,
  input wire logic i_thermal_trip_n,
  input wire logic i_crit_temp,
  input wire logic i_sleep_s4_n,
  input wire logic i_sleep_s3_n,
  input wire logic i_idle_sleep_n,
  input wire logic i_rail1_good,
  input wire logic i_rail2_good,
  input wire logic i_rail3_good,
  input wire logic i_rail4_good,
  input wire logic i_rail5_good,
  input wire logic i_rail6_good,
  // Outputs under watch
  input wire logic o_resume_reset_good_n,
  input wire logic o_platform_power_ok,
  input wire logic [pg_pkg::RAIL_N-1:0] o_rail_enable,
  input wire logic [pg_pkg::RAIL_N-1:0] o_discharge_on,
  input wire logic [pg_pkg::VCODE_W-1:0] o_rail1_vcode,
  input wire logic [pg_pkg::VCODE_W-1:0] o_rail2_vcode,
  input wire logic o_register_clear
);
  // ======================================
  // Clocking and the steps of a clear
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // Registers back at defaults, discharge follows a cycle later
  sequence s_defaults;
    (o_rail_enable == 6'h00) && (o_rail1_vcode == 7'h00) && (o_rail2_vcode == 7'h00)
      ##1 (o_discharge_on == 6'h3F);
  endsequence
  // Accepted write of the shutdown bit
  sequence s_soft_shutdown_bit_write;
    i_avs_write && !o_avs_waitrequest && (i_avs_address == pg_pkg::OFS_CTRL)
      && i_avs_byteenable[0] && i_avs_writedata[0];
  endsequence
  // ======================================
  // Assertions
  AST_DISCH_OFF: assert property ((o_discharge_on & $past(o_rail_enable)) == 6'h00)
    else $error("discharge on for an enabled rail");
  AST_RESUME_QUAL: assert property (o_resume_reset_good_n |-> $past(i_input_undervoltage_ok
    && i_chip_enable_in && i_rail1_good && i_rail4_good && i_rail5_good && !i_crit_temp))
    else $error("resume good without its qualifiers");
  AST_PLAT_QUAL: assert property (o_platform_power_ok |-> $past(i_sleep_s4_n && i_sleep_s3_n
    && i_rail2_good && i_rail3_good && i_rail6_good && i_rail4_good && i_rail5_good
    && i_input_undervoltage_ok && i_chip_enable_in)) else $error("platform ok unqualified");
  AST_PG_DROP: assert property (!i_chip_enable_in || i_crit_temp |=>
    !o_resume_reset_good_n && !o_platform_power_ok) else $error("power good not dropped");
  AST_SUPPLY_CLR: assert property (i_system_supply_low |=> o_register_clear)
    else $error("supply low gave no clear");
  AST_THERM_CLR: assert property ($fell(i_thermal_trip_n) && o_resume_reset_good_n
    |=> o_register_clear) else $error("thermal fall gave no clear");
  AST_CRIT_CLR: assert property ($rose(i_crit_temp) |=> o_register_clear)
    else $error("critical temperature gave no clear");
  AST_SOFT_SHUTDOWN_BIT_CLR: assert property (s_soft_shutdown_bit_write |=> o_register_clear)
    else $error("shutdown write gave no clear");
  AST_VCODE_CLR: assert property ($fell(i_idle_sleep_n) || $fell(i_sleep_s3_n) |=>
    (o_rail1_vcode == 7'h00) && (o_rail2_vcode == 7'h00)) else $error("vcode not cleared");
  AST_CLR_DEFAULTS: assert property (o_register_clear |=> s_defaults)
    else $error("clear did not restore defaults");
endmodule // pg_supervisor_sva

bind pg_supervisor pg_supervisor_sva pg_supervisor_sva_inst (.*);

//--- pg_host_model.sv
// Host model: platform controller driving the three sleep lines.
// Assumes the scenario sets requested levels right after a rising edge.
`timescale 1ns/1ps
module pg_host_model (
  // Clock
  input wire logic i_clk,
  // Requested levels {s4, s3, idle}, high = awake
  input wire logic [2:0] i_sleep_req,
  // Sleep lines toward the supervisor
  output logic o_sleep_s4_n,
  output logic o_sleep_s3_n,
  output logic o_idle_sleep_n
);
  // ======================================
  // Lines start awake and follow a request one cycle late, like controller flops
  initial begin
    {o_sleep_s4_n, o_sleep_s3_n, o_idle_sleep_n} = 3'h7;
  end
  always @(posedge i_clk) begin
    {o_sleep_s4_n, o_sleep_s3_n, o_idle_sleep_n} <= i_sleep_req;
  end
endmodule // pg_host_model

//--- tb.sv
// Self-checking bench for pg_supervisor with a host model on the sleep lines.
// Assumes pg_pkg, the design, the host model and the checker compile first.
`timescale 1ns/1ps
module tb;
  // ======================================
  // Signals carry the design port names so the instance connects by name
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [7:0] i_avs_address = 8'h00;
  logic i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [3:0] i_avs_byteenable = 4'hF;
  logic i_input_undervoltage_ok = 1'b1, i_system_supply_low = 1'b0, i_chip_enable_in = 1'b1;
  logic i_thermal_trip_n = 1'b1, i_crit_temp = 1'b0;
  logic i_rail1_good = 1'b1, i_rail2_good = 1'b1, i_rail3_good = 1'b1;
  logic i_rail4_good = 1'b1, i_rail5_good = 1'b1, i_rail6_good = 1'b1;
  logic [5:0] i_rail_fault = 6'h00;
  logic i_sleep_s4_n, i_sleep_s3_n, i_idle_sleep_n;
  logic [2:0] sleep_req = 3'h7;
  logic o_avs_waitrequest, o_resume_reset_good_n, o_platform_power_ok, o_register_clear;
  logic [31:0] o_avs_readdata, q;
  logic [5:0] o_rail_enable, o_discharge_on;
  logic [6:0] o_rail1_vcode, o_rail2_vcode;
  int errors = 0;
  int comparisons = 0;
  // Qualifiers {uv, en, trip_n, s4, s3, rail1..rail6, crit}, then {resume, platform}
  logic [15:0] rows [13] = '{16'hFFE3, 16'hFBE0, 16'hFFE3, 16'hFFC2, 16'hEFE2, 16'hF7E2,
    16'hFDE2, 16'hFEE2, 16'hFF60, 16'hFFA0, 16'h7FE0, 16'hFFF0, 16'hFFE3};

  // ======================================
  // Clock, design and host model
  initial begin
    forever #2.5 i_clk = ~i_clk;
  end
  pg_supervisor pg_supervisor_inst (.*);
  pg_host_model pg_host_model_inst (.i_clk(i_clk), .i_sleep_req(sleep_req),
    .o_sleep_s4_n(i_sleep_s4_n), .o_sleep_s3_n(i_sleep_s3_n), .o_idle_sleep_n(i_idle_sleep_n));

  // ======================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Let n edges pass and look at settled outputs mid-cycle
  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask
  // One bus transfer; request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] b);
    int n;
    n = 0;
    @(posedge i_clk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_byteenable <= b;
    i_avs_write <= w;
    i_avs_read <= !w;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 20);
    chk(32'(n < 20), 32'h1, "bus answer");
    q = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(q, e, "read data");
  endtask
  // Bounded wait for a power-good level; sel high picks platform ok
  task automatic wait_pg(input logic sel, input logic want);
    int n;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (((sel ? o_platform_power_ok : o_resume_reset_good_n) !== want) && n < 8);
    chk(32'(n < 8), 32'h1, "power good wait");
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ======================================
  // Watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge i_clk);
    errors++;
    end_of_test();
  end

  // ======================================
  // Main sequence
  initial begin
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    // Table of qualifier sets and the power-good levels they give
    foreach (rows[k]) begin
      @(posedge i_clk);
      {i_input_undervoltage_ok, i_chip_enable_in, i_thermal_trip_n, sleep_req[2:1], i_rail1_good,
        i_rail2_good, i_rail3_good, i_rail4_good, i_rail5_good, i_rail6_good, i_crit_temp}
        <= rows[k][15:4];
      settle(4);
      chk(32'({o_resume_reset_good_n, o_platform_power_ok}), 32'(rows[k][1:0]), "pg");
    end
    // Defaults after the critical clear, and an unmapped slot
    rdc(pg_pkg::OFS_CTRL, 32'h0);
    rdc(pg_pkg::OFS_FAULT_MASK, 32'h0);
    rdc(pg_pkg::OFS_DISCH, 32'h3F);
    rdc(pg_pkg::OFS_STATUS, 32'h003F000F);
    wr(pg_pkg::OFS_RAIL_EN, 32'h05);
    wr(pg_pkg::OFS_VCODE1, 32'h2A);
    wr(pg_pkg::OFS_VCODE2, 32'h55);
    bus(1'b1, pg_pkg::OFS_VCODE1, 32'h7F, 4'h0);
    wr(8'h1C, 32'hFF);
    rdc(8'h1C, 32'h0);
    chk(32'(o_discharge_on), 32'h3A, "discharge");
    chk(32'({o_rail1_vcode, o_rail2_vcode}), 32'h1555, "vcodes");
    // Idle sleep falling, then S3 falling, each wipe the voltage codes
    sleep_req <= 3'h6;
    settle(3);
    chk(32'({o_rail1_vcode, o_rail2_vcode}), 32'h0, "idle vcode clear");
    @(posedge i_clk);
    sleep_req <= 3'h7;
    wr(pg_pkg::OFS_VCODE2, 32'h55);
    @(posedge i_clk);
    sleep_req <= 3'h5;
    settle(3);
    chk(32'(o_rail2_vcode), 32'h0, "s3 vcode clear");
    @(posedge i_clk);
    sleep_req <= 3'h7;
    // A masked fault is ignored, an unmasked one clears everything
    wr(pg_pkg::OFS_FAULT_MASK, 32'h01);
    i_rail_fault <= 6'h01;
    settle(3);
    chk(32'({o_rail_enable, o_resume_reset_good_n}), 32'h0B, "masked fault");
    @(posedge i_clk);
    i_rail_fault <= 6'h03;
    settle(3);
    chk(32'({o_rail_enable, o_resume_reset_good_n}), 32'h00, "unmasked fault");
    @(posedge i_clk);
    i_rail_fault <= 6'h00;
    // Software shutdown, then a supply dip
    wr(pg_pkg::OFS_RAIL_EN, 32'h03);
    wr(pg_pkg::OFS_CTRL, 32'h01);
    settle(2);
    chk(32'(o_rail_enable), 32'h0, "soft shutdown");
    wr(pg_pkg::OFS_RAIL_EN, 32'h03);
    i_system_supply_low <= 1'b1;
    @(posedge i_clk);
    i_system_supply_low <= 1'b0;
    settle(2);
    chk(32'(o_rail_enable), 32'h0, "supply low");
    // Enable falling keeps registers with always-on set, clears them without
    wr(pg_pkg::OFS_CTRL, 32'h02);
    wr(pg_pkg::OFS_RAIL_EN, 32'h03);
    i_chip_enable_in <= 1'b0;
    settle(3);
    chk(32'(o_rail_enable), 32'h03, "enable fall kept");
    @(posedge i_clk);
    i_chip_enable_in <= 1'b1;
    wr(pg_pkg::OFS_CTRL, 32'h00);
    i_chip_enable_in <= 1'b0;
    settle(3);
    chk(32'(o_rail_enable), 32'h0, "enable fall cleared");
    // Fresh enable with rail1 down and a trip pending: platform rises, then rail1 joins
    @(posedge i_clk);
    {i_thermal_trip_n, i_rail1_good, i_chip_enable_in} <= 3'h1;
    wait_pg(1'b1, 1'b1);
    settle(3);
    chk(32'(o_platform_power_ok), 32'h0, "rail1 joined");
    @(posedge i_clk);
    i_rail1_good <= 1'b1;
    wait_pg(1'b0, 1'b1);
    settle(3);
    chk(32'(o_resume_reset_good_n), 32'h0, "trip armed");
    // Trip falling while resume good is up clears the registers
    @(posedge i_clk);
    i_thermal_trip_n <= 1'b1;
    wr(pg_pkg::OFS_RAIL_EN, 32'h03);
    wait_pg(1'b0, 1'b1);
    @(posedge i_clk);
    i_thermal_trip_n <= 1'b0;
    settle(3);
    chk(32'(o_rail_enable), 32'h0, "trip clear");
    end_of_test();
  end
endmodule // tb
